// ===== include/phy_regs_pkg.sv
// package for the memory information and receive/phy control slice
// assumes a 16-bit register port with 4-bit word offsets on ref_clk
package phy_regs_pkg;

    // register offsets as seen on the register port
    localparam logic [3:0] MEM_INFO_OFFSET  = 4'h8;
    localparam logic [3:0] RX_PHY_CTRL_OFFSET = 4'ha;

    // memory information layout: free in the high byte, total in the low
    localparam int unsigned FREE_LSB  = 8;
    localparam int unsigned TOTAL_LSB = 0;
    localparam int unsigned BYTE_W    = 8;

    // total buffer size in 2K * multiplier units, multiplier is one
    localparam int unsigned MEM_MULT        = 1;
    localparam logic [7:0]  MEM_TOTAL_UNITS = 8'h04;

    // receive/phy control field positions
    localparam int unsigned SPEED_BIT      = 13;
    localparam int unsigned DUPLEX_BIT     = 12;
    localparam int unsigned AUTONEG_BIT    = 11;
    localparam int unsigned LED_A_SEL_LSB  = 5;
    localparam int unsigned LED_B_SEL_LSB  = 2;
    localparam int unsigned LED_SEL_W      = 3;
    localparam logic [15:0] RX_PHY_RESET   = 16'h0000;
    localparam logic [15:0] RX_PHY_WMASK   = 16'h38fc;

    // led selector codes
    typedef enum logic [2:0] {
        LED_ANY_LINK, LED_RSVD, LED_LINK10, LED_FULL_DUPLEX,
        LED_ACTIVITY, LED_LINK100, LED_RECEIVE, LED_TRANSMIT
    } led_code_t;

    // phy register 0 control bits as seen by this block
    typedef struct packed {
        logic speed_100;
        logic full_duplex;
        logic autoneg_enable;
    } phy_ctrl_t;

    // outcome of auto-negotiation
    typedef struct packed {
        logic speed_100;
        logic full_duplex;
    } autoneg_select_result_t;

    // resolved operating mode handed to the phy
    typedef struct packed {
        logic speed_100;
        logic full_duplex;
        logic autoneg_run;
    } phy_mode_t;

    // phy status indications, active high
    typedef struct packed {
        logic link10_ind;
        logic full_duplex_ind;
        logic activity_ind;
        logic link100_ind;
        logic receive_ind;
        logic transmit_ind;
    } led_ind_t;

    // free-space report from the buffer manager
    typedef struct packed {
        logic       valid;
        logic [7:0] units;
    } buf_free_t;

endpackage

// ===== logic/led_mux.sv
// one led output selected from the phy indications
// assumes indications come from logic on ref_clk
module led_mux (
    input  wire logic                    ref_clk,
    input  wire logic                    reset_n,
    input  wire logic [2:0]              sel,
    input  wire phy_regs_pkg::led_ind_t  ind,
    output logic                         led
);

    // map a selector code onto one indication
    function automatic logic pick(input logic [2:0] code,
                                  input phy_regs_pkg::led_ind_t i);
        logic r;
        r = 1'b0;
        case (phy_regs_pkg::led_code_t'(code))
            phy_regs_pkg::LED_ANY_LINK:    r = i.link100_ind | i.link10_ind;
            phy_regs_pkg::LED_RSVD:        r = 1'b0;
            phy_regs_pkg::LED_LINK10:      r = i.link10_ind;
            phy_regs_pkg::LED_FULL_DUPLEX: r = i.full_duplex_ind;
            phy_regs_pkg::LED_ACTIVITY:    r = i.activity_ind;
            phy_regs_pkg::LED_LINK100:     r = i.link100_ind;
            phy_regs_pkg::LED_RECEIVE:     r = i.receive_ind;
            phy_regs_pkg::LED_TRANSMIT:    r = i.transmit_ind;
            default:                       r = 1'b0;
        endcase
        return r;
    endfunction

    // registered led drive
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            led <= 1'b0;
        end else begin
            led <= pick(sel, ind);
        end
    end

endmodule

// ===== logic/phy_mode_led_select_regs.sv
// memory information and receive/phy control registers with led select
// assumes phy status, phy control and buffer-manager inputs on ref_clk
//
// Design decision made here: the plain strobed port.
module phy_mode_led_select_regs (
    input  wire logic                        ref_clk,
    input  wire logic                        reset_n,
    input  wire logic [3:0]                  addr,
    input  wire logic [15:0]                 wdata,
    input  wire logic                        wr_en,
    input  wire logic                        rd_en,
    output logic [15:0]                      rdata,
    input  wire logic                        mmu_reset,
    input  wire phy_regs_pkg::buf_free_t     buf_free,
    input  wire phy_regs_pkg::phy_ctrl_t     phy_ctrl,
    input  wire phy_regs_pkg::autoneg_select_result_t  autoneg_select_result,
    input  wire phy_regs_pkg::led_ind_t      led_ind,
    output phy_regs_pkg::phy_mode_t          phy_mode,
    output logic                             led_out_first,
    output logic                             led_out_second
);

    logic [7:0]  free_reg;
    logic [7:0]  free_next;
    logic [15:0] rx_phy_reg;
    logic [15:0] rx_phy_next;
    logic [15:0] rdata_next;
    logic        speed_select;
    logic        duplex_select;
    logic        autoneg_select;
    logic [2:0]  led_sel [2];
    logic [1:0]  led_drv;
    logic        hit_mem;
    logic        hit_ctrl;

    // address decode
    assign hit_mem  = (addr == phy_regs_pkg::MEM_INFO_OFFSET);
    assign hit_ctrl = (addr == phy_regs_pkg::RX_PHY_CTRL_OFFSET);

    // control field taps
    assign speed_select   = rx_phy_reg[phy_regs_pkg::SPEED_BIT];
    assign duplex_select  = rx_phy_reg[phy_regs_pkg::DUPLEX_BIT];
    assign autoneg_select = rx_phy_reg[phy_regs_pkg::AUTONEG_BIT];
    assign led_sel[0] =
        rx_phy_reg[phy_regs_pkg::LED_A_SEL_LSB +: phy_regs_pkg::LED_SEL_W];
    assign led_sel[1] =
        rx_phy_reg[phy_regs_pkg::LED_B_SEL_LSB +: phy_regs_pkg::LED_SEL_W];

    // free space: mmu reset reloads total, else follow buffer manager
    always_comb begin
        free_next = free_reg;
        if (mmu_reset) begin
            free_next = phy_regs_pkg::MEM_TOTAL_UNITS;
        end else if (buf_free.valid) begin
            free_next = buf_free.units;
        end
    end

    // free space register, power-on value is the total size
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            free_reg <= phy_regs_pkg::MEM_TOTAL_UNITS;
        end else begin
            free_reg <= free_next;
        end
    end

    // control register write, reserved bits stay zero
    always_comb begin
        rx_phy_next = rx_phy_reg;
        if (wr_en && hit_ctrl) begin
            rx_phy_next = wdata & phy_regs_pkg::RX_PHY_WMASK;
        end
    end

    // control register, selectors reset to the any-link code
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_phy_reg <= phy_regs_pkg::RX_PHY_RESET;
        end else begin
            rx_phy_reg <= rx_phy_next;
        end
    end

    // read mux; unmapped offsets read zero
    always_comb begin
        rdata_next = 16'h0000;
        if (hit_mem) begin
            rdata_next[phy_regs_pkg::FREE_LSB +: phy_regs_pkg::BYTE_W] =
                free_reg;
            rdata_next[phy_regs_pkg::TOTAL_LSB +: phy_regs_pkg::BYTE_W] =
                phy_regs_pkg::MEM_TOTAL_UNITS;
        end else if (hit_ctrl) begin
            rdata_next = rx_phy_reg;
        end
    end

    // read data stands only in the cycle after the read strobe
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata <= 16'h0000;
        end else if (rd_en) begin
            rdata <= rdata_next;
        end else begin
            rdata <= 16'h0000;
        end
    end

    // speed and duplex resolution and negotiation enable
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            phy_mode <= '0;
        end else if (!autoneg_select) begin
            phy_mode.speed_100   <= speed_select;
            phy_mode.full_duplex <= duplex_select;
            phy_mode.autoneg_run <= 1'b0;
        end else if (phy_ctrl.autoneg_enable) begin
            phy_mode.speed_100   <= autoneg_select_result.speed_100;
            phy_mode.full_duplex <= autoneg_select_result.full_duplex;
            phy_mode.autoneg_run <= 1'b1;
        end else begin
            phy_mode.speed_100   <= phy_ctrl.speed_100;
            phy_mode.full_duplex <= phy_ctrl.full_duplex;
            phy_mode.autoneg_run <= 1'b0;
        end
    end

    // one selector per led, both share the same code map
    for (genvar g = 0; g < 2; g++) begin : g_led
        led_mux u_led (
            .ref_clk (ref_clk),
            .reset_n (reset_n),
            .sel     (led_sel[g]),
            .ind     (led_ind),
            .led     (led_drv[g])
        );
    end

    assign led_out_first  = led_drv[0];
    assign led_out_second = led_drv[1];

    // expected led level for a selector code, used by the checks
    function automatic logic led_expect(input logic [2:0] code,
                                        input phy_regs_pkg::led_ind_t i);
        logic r;
        r = 1'b0;
        case (code)
            3'h0:    r = i.link100_ind | i.link10_ind;
            3'h2:    r = i.link10_ind;
            3'h3:    r = i.full_duplex_ind;
            3'h4:    r = i.activity_ind;
            3'h5:    r = i.link100_ind;
            3'h6:    r = i.receive_ind;
            3'h7:    r = i.transmit_ind;
            default: r = 1'b0;
        endcase
        return r;
    endfunction

    // checks on the register port

    // free amount read back in the high byte
    chk_free_readback: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        (rd_en && hit_mem && !mmu_reset && !buf_free.valid)
        |=> rdata[phy_regs_pkg::FREE_LSB +: phy_regs_pkg::BYTE_W] == free_reg
    ) else $error("free memory byte does not match free space");

    // total size always reads in the low byte
    chk_total_size: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        (rd_en && hit_mem) |=>
            rdata[phy_regs_pkg::TOTAL_LSB +: phy_regs_pkg::BYTE_W] ==
            phy_regs_pkg::MEM_TOTAL_UNITS
    ) else $error("memory size byte is wrong");

    // mmu reset reloads free space with the total
    chk_mmu_reload: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        mmu_reset |=> free_reg == phy_regs_pkg::MEM_TOTAL_UNITS
    ) else $error("free space not reloaded on mmu reset");

    // mmu reset followed by a read reports the total as free
    chk_reload_visible: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        (mmu_reset ##1 (rd_en && hit_mem && !mmu_reset && !buf_free.valid))
        |=> rdata[phy_regs_pkg::FREE_LSB +: phy_regs_pkg::BYTE_W] ==
            phy_regs_pkg::MEM_TOTAL_UNITS
    ) else $error("free space after mmu reset not the total");

    // checks on mode resolution

    // manual speed follows the speed bit
    chk_manual_speed: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        !autoneg_select |=> phy_mode.speed_100 == $past(speed_select)
    ) else $error("manual speed not forced by speed bit");

    // auto speed ignores the speed bit
    chk_auto_speed: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        autoneg_select |=> phy_mode.speed_100 ==
            ($past(phy_ctrl.autoneg_enable) ? $past(autoneg_select_result.speed_100)
                                            : $past(phy_ctrl.speed_100))
    ) else $error("auto speed not from negotiation or phy control");

    // manual duplex follows the duplex bit
    chk_manual_duplex: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        !autoneg_select |=> phy_mode.full_duplex == $past(duplex_select)
    ) else $error("manual duplex not forced by duplex bit");

    // auto duplex ignores the duplex bit
    chk_auto_duplex: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        autoneg_select |=> phy_mode.full_duplex ==
            ($past(phy_ctrl.autoneg_enable) ? $past(autoneg_select_result.full_duplex)
                                            : $past(phy_ctrl.full_duplex))
    ) else $error("auto duplex not from negotiation or phy control");

    // negotiation runs only with both enables
    chk_autoneg_select_both: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        1'b1 |=> phy_mode.autoneg_run ==
            ($past(autoneg_select) && $past(phy_ctrl.autoneg_enable))
    ) else $error("negotiation enable does not need both bits");

    // checks on led selection

    // first led follows its selector
    chk_led_first: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        1'b1 |=> led_out_first == led_expect($past(led_sel[0]),
                                             $past(led_ind))
    ) else $error("first led shows the wrong indication");

    // default code gives combined link on the first led
    chk_led_first_dflt: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        (led_sel[0] == 3'h0) |=> led_out_first ==
            ($past(led_ind.link100_ind) | $past(led_ind.link10_ind))
    ) else $error("first led default is not combined link");

    // second led shares the map
    chk_led_second: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        1'b1 |=> led_out_second == led_expect($past(led_sel[1]),
                                              $past(led_ind))
    ) else $error("second led shows the wrong indication");

    // reserved code keeps a led dark
    chk_led_reserved: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        (led_sel[1] == 3'h1) |=> !led_out_second
    ) else $error("reserved led code lights the led");

    // main scenarios
    cov_mmu_reload: cover property (
        @(posedge ref_clk) disable iff (!reset_n)
        mmu_reset ##1 (rd_en && hit_mem)
    );

    cov_manual_mode: cover property (
        @(posedge ref_clk) disable iff (!reset_n)
        (wr_en && hit_ctrl && !wdata[phy_regs_pkg::AUTONEG_BIT]
         && wdata[phy_regs_pkg::SPEED_BIT])
    );

    cov_auto_mode: cover property (
        @(posedge ref_clk) disable iff (!reset_n)
        autoneg_select && phy_ctrl.autoneg_enable ##1 phy_mode.autoneg_run
    );

    cov_led_codes: cover property (
        @(posedge ref_clk) disable iff (!reset_n)
        (led_sel[0] == 3'h7) && (led_sel[1] == 3'h4)
    );

endmodule

// ===== tb/phy_model.sv
// behavioural model of the internal phy feeding the register slice
// assumes the bench calls its tasks; values change just after ref_clk
module phy_model (
    input  wire logic                        ref_clk,
    input  wire phy_regs_pkg::phy_mode_t     phy_mode,
    output phy_regs_pkg::phy_ctrl_t          phy_ctrl,
    output phy_regs_pkg::autoneg_select_result_t       autoneg_select_result,
    output phy_regs_pkg::led_ind_t           led_ind
);
    timeunit 1ns;
    timeprecision 100ps;

    // duplex the phy is running in; host must match the mac to it
    logic duplex_reg;
    always @(posedge ref_clk) begin
        duplex_reg <= phy_mode.full_duplex;
    end

    // phy powers up in manual mode with no link
    initial begin
        phy_ctrl    = '0;
        autoneg_select_result = '0;
        led_ind     = '0;
    end

    // control bits of phy register 0 and the negotiated outcome
    task automatic set_ctrl(input phy_regs_pkg::phy_ctrl_t c,
                            input phy_regs_pkg::autoneg_select_result_t r);
        @(posedge ref_clk);
        phy_ctrl    <= c;
        autoneg_select_result <= r;
    endtask

    // status indications routed towards the led pins
    task automatic set_ind(input phy_regs_pkg::led_ind_t i);
        @(posedge ref_clk);
        led_ind <= i;
    endtask
endmodule

// ===== tb/phy_mode_led_select_regs_bench.sv
// self-checking bench for the memory info and rx/phy control slice
// assumes the phy model beside the design and a 40 MHz ref_clk
module phy_mode_led_select_regs_bench;
    timeunit 1ns;
    timeprecision 100ps;

    logic                        ref_clk   = 1'b0;
    logic                        reset_n   = 1'b0;
    logic [3:0]                  addr      = 4'h0;
    logic [15:0]                 wdata     = 16'h0000;
    logic                        wr_en     = 1'b0;
    logic                        rd_en     = 1'b0;
    logic [15:0]                 rdata;
    logic                        mmu_reset = 1'b0;
    phy_regs_pkg::buf_free_t     buf_free  = '0;
    phy_regs_pkg::phy_ctrl_t     phy_ctrl;
    phy_regs_pkg::autoneg_select_result_t  autoneg_select_result;
    phy_regs_pkg::led_ind_t      led_ind;
    phy_regs_pkg::phy_mode_t     phy_mode;
    logic                        led_out_first;
    logic                        led_out_second;
    logic                        rd_seen   = 1'b0;
    logic [15:0]                 exp_q[$];
    logic [15:0]                 exp_rd;
    int                          err_total   = 0;
    int                          comparisons = 0;
    integer                      seed        = 32'h1e97;

    always #12.5 ref_clk = ~ref_clk;

    phy_mode_led_select_regs dut (
        .ref_clk(ref_clk), .reset_n(reset_n), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
        .mmu_reset(mmu_reset), .buf_free(buf_free), .phy_ctrl(phy_ctrl),
        .autoneg_select_result(autoneg_select_result), .led_ind(led_ind), .phy_mode(phy_mode),
        .led_out_first(led_out_first), .led_out_second(led_out_second)
    );

    phy_model phy (
        .ref_clk(ref_clk), .phy_mode(phy_mode), .phy_ctrl(phy_ctrl),
        .autoneg_select_result(autoneg_select_result), .led_ind(led_ind)
    );

    // one comparison, counted, reported at once on a mismatch
    task automatic chk(input logic [15:0] got, input logic [15:0] want);
        comparisons++;
        if (got !== want) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, want);
        end
    endtask

    // single-cycle register write
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        addr  <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge ref_clk);
        wr_en <= 1'b0;
    endtask

    // single-cycle register read, expectation noted in the queue
    task automatic rd(input logic [3:0] a, input logic [15:0] want);
        @(posedge ref_clk);
        addr  <= a;
        rd_en <= 1'b1;
        exp_q.push_back(want);
        @(posedge ref_clk);
        rd_en <= 1'b0;
    endtask

    // read data are looked at only in the cycle after the strobe
    always @(posedge ref_clk) begin
        if (rd_seen) begin
            exp_rd = exp_q.pop_front();
            chk(rdata, exp_rd);
        end
        rd_seen <= rd_en;
    end

    // expected led level for a selector code
    function automatic logic led_exp(input logic [2:0] c,
                                     input phy_regs_pkg::led_ind_t i);
        case (c)
            3'h0: led_exp = i.link10_ind | i.link100_ind;
            3'h1: led_exp = 1'b0;
            3'h2: led_exp = i.link10_ind;
            3'h3: led_exp = i.full_duplex_ind;
            3'h4: led_exp = i.activity_ind;
            3'h5: led_exp = i.link100_ind;
            3'h6: led_exp = i.receive_ind;
            default: led_exp = i.transmit_ind;
        endcase
    endfunction

    // verdict and end of run
    task automatic close_out();
        if (err_total == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // watchdog at 20000 cycles, well beyond the expected run of under two thousand cycles
    initial begin
        #(25 * 20000);
        err_total++;
        close_out();
    end

    // main sequence
    initial begin
        logic [15:0]            d;
        logic [7:0]             i;
        logic [2:0]             c;
        logic                   sp;
        logic                   dp;
        logic                   mac_full_duplex;
        phy_regs_pkg::led_ind_t ind;
        repeat (3) @(posedge ref_clk);
        reset_n <= 1'b1;
        rd(4'h8, 16'h0404);
        rd(4'ha, 16'h0000);
        rd(4'h3, 16'h0000);
        wr(4'h8, 16'hffff);
        rd(4'h8, 16'h0404);
        // default selectors show the combined link indication
        ind = phy_regs_pkg::led_ind_t'($random(seed));
        phy.set_ind(ind);
        repeat (3) @(posedge ref_clk);
        #1 chk(16'(led_out_first), 16'(led_exp(3'h0, ind)));
        chk({15'h0, led_out_second}, {15'h0, led_exp(3'h0, ind)});
        // random writes read back through the writable mask
        repeat (4) begin
            d = 16'($random(seed));
            wr(4'ha, d);
            rd(4'ha, d & 16'h38fc);
        end
        // free space update, then buffer-manager reset wins over it
        @(posedge ref_clk);
        buf_free <= '{valid: 1'b1, units: 8'h03};
        @(posedge ref_clk);
        buf_free <= '0;
        rd(4'h8, 16'h0304);
        @(posedge ref_clk);
        mmu_reset <= 1'b1;
        buf_free  <= '{valid: 1'b1, units: 8'h01};
        @(posedge ref_clk);
        mmu_reset <= 1'b0;
        buf_free  <= '0;
        rd(4'h8, 16'h0404);
        // every mix of select bits, phy control and negotiation result
        for (int n = 0; n < 256; n++) begin
            i = 8'(n);
            wr(4'ha, {2'b00, i[0], i[1], i[2], 11'h000});
            phy.set_ctrl(i[5:3], i[7:6]);
            repeat (3) @(posedge ref_clk);
            sp = !i[2] ? i[0] : (i[3] ? i[7] : i[5]);
            dp = !i[2] ? i[1] : (i[3] ? i[6] : i[4]);
            mac_full_duplex = dp;
            #1 chk(16'(phy_mode.speed_100), 16'(sp));
            chk(16'(phy_mode.full_duplex), 16'(dp));
            chk(16'(phy_mode.autoneg_run), 16'(i[2] & i[3]));
            chk(16'(phy.duplex_reg), 16'(mac_full_duplex));
        end
        // every selector code on both leds with random indications
        for (int n = 0; n < 8; n++) begin
            c = 3'(n);
            wr(4'ha, {8'h00, c, ~c, 2'b00});
            repeat (4) begin
                ind = phy_regs_pkg::led_ind_t'($random(seed));
                phy.set_ind(ind);
                repeat (3) @(posedge ref_clk);
                #1 chk(16'(led_out_first), 16'(led_exp(c, ind)));
                chk(16'(led_out_second), 16'(led_exp(~c, ind)));
            end
        end
        repeat (3) @(posedge ref_clk);
        close_out();
    end
endmodule
